// ===== design/msr_defs.svh
`ifndef MSR_DEFS_SVH
`define MSR_DEFS_SVH

// Register byte offsets
`define MSR_OFF_CTRL       8'h00
`define MSR_OFF_HWDT_TMO   8'h04
`define MSR_OFF_HWDT_STAT  8'h08
`define MSR_OFF_CFG        8'h0C
`define MSR_OFF_BAUD       8'h10
`define MSR_OFF_DO_SAFE    8'h14
`define MSR_OFF_DO_PWRON   8'h18
`define MSR_OFF_DO_VAL     8'h1C
`define MSR_OFF_STATUS     8'h20
`define MSR_OFF_IRQ_STAT   8'h24
`define MSR_OFF_IRQ_MASK   8'h28

// Field positions
`define MSR_CTRL_HWDT_EN   0
`define MSR_CFG_CKSUM_BIT  8
`define MSR_CFG_PROTO_BIT  9
`define MSR_ST_INIT_BIT    0
`define MSR_ST_RSTF_BIT    1
`define MSR_ST_HTMO_BIT    2
`define MSR_ST_BUSY_BIT    3
`define MSR_IRQ_HTMO_BIT   0
`define MSR_IRQ_MRST_BIT   1
`define MSR_IRQ_CMD_BIT    2
`define MSR_IRQ_W          3

// Init-mode defaults and reset values
`define MSR_DEF_ADDR       8'h00
`define MSR_DEF_BAUD       18'h02580
`define MSR_DEF_CKSUM      1'b0
`define MSR_DEF_PROTO      1'b0
`define MSR_RST_DO_PWRON   4'h0
`define MSR_RST_DO_SAFE    4'h0
`define MSR_RST_HWDT_TMO   8'h00

// Timing
`define MSR_CLK_MHZ        100
`define MSR_TENTH_S_MS     100
`define MSR_MWDT_MS        500
`define MSR_INIT_SAMPLE    2'h3

`endif

// ===== design/msr_pkg.sv
package msr_pkg;

    typedef enum logic [2:0] {
        CMD_OTHER           = 3'b000,
        CMD_READ_CONFIG     = 3'b001,
        CMD_READ_RESET_FLAG = 3'b010,
        CMD_SET_CONFIG      = 3'b011,
        CMD_SELECT_PROTOCOL = 3'b100
    } msr_cmd_t;

    typedef enum logic {
        ST_IDLE = 1'b0,
        ST_BUSY = 1'b1
    } msr_state_t;

endpackage

// ===== design/msr_sync2.sv
`timescale 1ns/1ps
module msr_sync2 #(
    parameter logic RST_VAL = 1'b1
) (
    input  wire logic i_clk,
    input  wire logic i_rst_n,
    input  wire logic i_async,
    output logic      o_sync
);
    logic meta_reg;
    logic sync_reg;

    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            meta_reg <= RST_VAL;
            sync_reg <= RST_VAL;
        end
        else
        begin
            meta_reg <= i_async;
            sync_reg <= meta_reg;
        end
    end

    assign o_sync = sync_reg;
endmodule // msr_sync2

// ===== design/msr_tick.sv
`timescale 1ns/1ps
module msr_tick #(
    parameter int CYCLES = 16
) (
    input  wire logic i_clk,
    input  wire logic i_rst_n,
    input  wire logic i_clear,
    output logic      o_tick
);
    localparam int W = (CYCLES > 2) ? $clog2(CYCLES) : 1;
    localparam logic [W-1:0] LAST = W'(CYCLES - 1);

    logic [W-1:0] cnt_reg;
    logic [W-1:0] cnt_next;
    logic         at_last;

    generate
        if (CYCLES < 2)
        begin : g_bad
            $error("msr_tick: CYCLES must be at least 2");
        end
    endgenerate

    assign at_last  = (cnt_reg == LAST);
    assign cnt_next = (i_clear || at_last) ? '0 : cnt_reg + W'(1);
    assign o_tick   = at_last && !i_clear;

    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            cnt_reg <= '0;
        else
            cnt_reg <= cnt_next;
    end
endmodule // msr_tick

// ===== design/msr_top.sv
// The implementer's own choices: the APB register port and the register offsets.
`timescale 1ns/1ps
`include "msr_defs.svh"
module msr_top #(
    parameter int TENTH_CYCLES = `MSR_TENTH_S_MS * 1000 * `MSR_CLK_MHZ,
    parameter int MWDT_CYCLES  = `MSR_MWDT_MS * 1000 * `MSR_CLK_MHZ
) (
    input  wire logic              I_CORE_CLK,
    input  wire logic              I_RST_N,
    input  wire logic              I_INIT_N,
    input  wire logic              I_ALIVE,
    input  wire logic              I_CMD_VALID,
    input  wire logic              I_CMD_FOR_ME,
    input  wire msr_pkg::msr_cmd_t I_CMD_KIND,
    input  wire logic [7:0]        I_CMD_ADDR,
    input  wire logic [17:0]       I_CMD_BAUD,
    input  wire logic              I_CMD_CKSUM,
    input  wire logic              I_CMD_PROTO,
    input  wire logic              I_RSP_DONE,
    input  wire logic              I_PSEL,
    input  wire logic              I_PENABLE,
    input  wire logic              I_PWRITE,
    input  wire logic [7:0]        I_PADDR,
    input  wire logic [31:0]       I_PWDATA,
    output logic [31:0]            O_PRDATA,
    output logic                   O_PREADY,
    output logic                   O_PSLVERR,
    output logic                   O_CMD_ACCEPT,
    output logic                   O_PWR_LED,
    output logic                   O_INIT_MODE,
    output logic [7:0]             O_EFF_ADDR,
    output logic [17:0]            O_EFF_BAUD,
    output logic                   O_EFF_CKSUM,
    output logic                   O_EFF_PROTO,
    output logic [27:0]            O_STORED_CFG,
    output logic                   O_RST_FLAG,
    output logic                   O_HWDT_TMO,
    output logic                   O_MOD_RST,
    output logic [3:0]             O_DO,
    output logic                   O_IRQ
);
    import msr_pkg::*;

    logic                  init_sync;
    logic [1:0]            smp_cnt_reg;
    logic                  smp_done_reg;
    logic                  init_mode_reg;
    msr_state_t            state_reg;
    msr_cmd_t              kind_reg;
    logic                  hwdt_en_reg;
    logic [7:0]            hwdt_tmo_reg;
    logic [7:0]            hwdt_cnt_reg;
    logic                  hwdt_stat_reg;
    logic [7:0]            cfg_addr_reg;
    logic [17:0]           cfg_baud_reg;
    logic                  cfg_cksum_reg;
    logic                  cfg_proto_reg;
    logic [3:0]            do_safe_reg;
    logic [3:0]            do_pwron_reg;
    logic [3:0]            do_reg;
    logic                  rst_flag_reg;
    logic                  mod_rst_reg;
    logic [`MSR_IRQ_W-1:0] irq_stat_reg;
    logic [`MSR_IRQ_W-1:0] irq_mask_reg;
    logic [31:0]           rdata_reg;

    // Strap caught only after the synchroniser has filled past reset
    msr_sync2 #(
        .RST_VAL (1'b1)
    ) u_init_sync (
        .i_clk   (I_CORE_CLK),
        .i_rst_n (I_RST_N),
        .i_async (I_INIT_N),
        .o_sync  (init_sync)
    );

    always_ff @(posedge I_CORE_CLK or negedge I_RST_N)
    begin
        if (!I_RST_N)
        begin
            smp_cnt_reg   <= 2'h0;
            smp_done_reg  <= 1'b0;
            init_mode_reg <= 1'b0;
        end
        else if (!smp_done_reg)
        begin
            smp_cnt_reg <= smp_cnt_reg + 2'h1;
            if (smp_cnt_reg == `MSR_INIT_SAMPLE)
            begin
                smp_done_reg  <= 1'b1;
                init_mode_reg <= !init_sync;
            end
        end
    end

    // Command handshake
    logic cmd_take;
    logic restricted;
    logic rsp_end;
    assign cmd_take = I_CMD_VALID && I_CMD_FOR_ME;
    // Address-only changes pass outside init mode
    assign restricted = (I_CMD_KIND == CMD_SELECT_PROTOCOL) ||
                        ((I_CMD_KIND == CMD_SET_CONFIG) &&
                         ((I_CMD_BAUD != cfg_baud_reg) ||
                          (I_CMD_CKSUM != cfg_cksum_reg)));
    assign O_CMD_ACCEPT = cmd_take && (!restricted || init_mode_reg);
    assign rsp_end = (state_reg == ST_BUSY) && I_RSP_DONE;

    always_ff @(posedge I_CORE_CLK or negedge I_RST_N)
    begin
        if (!I_RST_N)
        begin
            state_reg <= ST_IDLE;
            kind_reg  <= CMD_OTHER;
        end
        else if (mod_rst_reg)
            state_reg <= ST_IDLE;
        else
        begin
            unique case (state_reg)
                ST_IDLE:
                begin
                    if (cmd_take)
                    begin
                        state_reg <= ST_BUSY;
                        kind_reg  <= I_CMD_KIND;
                    end
                end
                ST_BUSY:
                begin
                    if (cmd_take)
                        kind_reg <= I_CMD_KIND;
                    else if (I_RSP_DONE)
                        state_reg <= ST_IDLE;
                end
            endcase
        end
    end

    assign O_PWR_LED = (state_reg == ST_IDLE);

    // APB slave, zero wait states
    logic setup;
    logic wr_en;
    logic rd_en;
    assign setup = I_PSEL && !I_PENABLE;
    assign wr_en = I_PSEL && I_PENABLE && I_PWRITE;
    assign rd_en = I_PSEL && I_PENABLE && !I_PWRITE;

    logic hit_ctrl, hit_tmo, hit_hstat, hit_cfg, hit_baud, hit_safe;
    logic hit_pwron, hit_do, hit_status, hit_istat, hit_imask, mapped;
    assign hit_ctrl   = (I_PADDR == `MSR_OFF_CTRL);
    assign hit_tmo    = (I_PADDR == `MSR_OFF_HWDT_TMO);
    assign hit_hstat  = (I_PADDR == `MSR_OFF_HWDT_STAT);
    assign hit_cfg    = (I_PADDR == `MSR_OFF_CFG);
    assign hit_baud   = (I_PADDR == `MSR_OFF_BAUD);
    assign hit_safe   = (I_PADDR == `MSR_OFF_DO_SAFE);
    assign hit_pwron  = (I_PADDR == `MSR_OFF_DO_PWRON);
    assign hit_do     = (I_PADDR == `MSR_OFF_DO_VAL);
    assign hit_status = (I_PADDR == `MSR_OFF_STATUS);
    assign hit_istat  = (I_PADDR == `MSR_OFF_IRQ_STAT);
    assign hit_imask  = (I_PADDR == `MSR_OFF_IRQ_MASK);
    assign mapped = hit_ctrl | hit_tmo | hit_hstat | hit_cfg | hit_baud |
                    hit_safe | hit_pwron | hit_do | hit_status |
                    hit_istat | hit_imask;

    logic [31:0] cfg_word;
    logic [31:0] status_word;
    logic [31:0] rd_mux;
    assign cfg_word = {22'h0, cfg_proto_reg, cfg_cksum_reg, cfg_addr_reg};
    assign status_word = {28'h0, (state_reg == ST_BUSY), hwdt_stat_reg,
                          rst_flag_reg, init_mode_reg};
    assign rd_mux =
        ({32{hit_ctrl}}   & {31'h0, hwdt_en_reg}) |
        ({32{hit_tmo}}    & {24'h0, hwdt_tmo_reg}) |
        ({32{hit_hstat}}  & {31'h0, hwdt_stat_reg}) |
        ({32{hit_cfg}}    & cfg_word) |
        ({32{hit_baud}}   & {14'h0, cfg_baud_reg}) |
        ({32{hit_safe}}   & {28'h0, do_safe_reg}) |
        ({32{hit_pwron}}  & {28'h0, do_pwron_reg}) |
        ({32{hit_do}}     & {28'h0, do_reg}) |
        ({32{hit_status}} & status_word) |
        ({32{hit_istat}}  & {29'h0, irq_stat_reg}) |
        ({32{hit_imask}}  & {29'h0, irq_mask_reg});

    always_ff @(posedge I_CORE_CLK or negedge I_RST_N)
    begin
        if (!I_RST_N)
            rdata_reg <= 32'h0;
        else if (setup)
            rdata_reg <= rd_mux;
    end

    assign O_PRDATA  = rdata_reg;
    assign O_PREADY  = 1'b1;
    assign O_PSLVERR = I_PSEL && I_PENABLE && !mapped;

    // Plain control registers
    always_ff @(posedge I_CORE_CLK or negedge I_RST_N)
    begin
        if (!I_RST_N)
        begin
            hwdt_en_reg  <= 1'b0;
            hwdt_tmo_reg <= `MSR_RST_HWDT_TMO;
            do_safe_reg  <= `MSR_RST_DO_SAFE;
            do_pwron_reg <= `MSR_RST_DO_PWRON;
            irq_mask_reg <= '0;
        end
        else if (wr_en)
        begin
            if (hit_ctrl)
                hwdt_en_reg <= I_PWDATA[`MSR_CTRL_HWDT_EN];
            if (hit_tmo)
                hwdt_tmo_reg <= I_PWDATA[7:0];
            if (hit_safe)
                do_safe_reg <= I_PWDATA[3:0];
            if (hit_pwron)
                do_pwron_reg <= I_PWDATA[3:0];
            if (hit_imask)
                irq_mask_reg <= I_PWDATA[`MSR_IRQ_W-1:0];
        end
    end

    // Stored configuration; init mode masks it at the outputs and unlocks baud and flag writes
    logic take_cfg;
    logic take_proto;
    assign take_cfg   = O_CMD_ACCEPT && (I_CMD_KIND == CMD_SET_CONFIG);
    assign take_proto = O_CMD_ACCEPT && (I_CMD_KIND == CMD_SELECT_PROTOCOL);

    always_ff @(posedge I_CORE_CLK or negedge I_RST_N)
    begin
        if (!I_RST_N)
        begin
            cfg_addr_reg  <= `MSR_DEF_ADDR;
            cfg_baud_reg  <= `MSR_DEF_BAUD;
            cfg_cksum_reg <= `MSR_DEF_CKSUM;
            cfg_proto_reg <= `MSR_DEF_PROTO;
        end
        else if (take_cfg || take_proto)
        begin
            if (take_cfg)
            begin
                cfg_addr_reg  <= I_CMD_ADDR;
                cfg_baud_reg  <= I_CMD_BAUD;
                cfg_cksum_reg <= I_CMD_CKSUM;
            end
            if (take_proto)
                cfg_proto_reg <= I_CMD_PROTO;
        end
        else if (wr_en)
        begin
            if (hit_cfg)
                cfg_addr_reg <= I_PWDATA[7:0];
            if (hit_cfg && init_mode_reg)
            begin
                cfg_cksum_reg <= I_PWDATA[`MSR_CFG_CKSUM_BIT];
                cfg_proto_reg <= I_PWDATA[`MSR_CFG_PROTO_BIT];
            end
            if (hit_baud && init_mode_reg)
                cfg_baud_reg <= I_PWDATA[17:0];
        end
    end

    assign O_INIT_MODE  = init_mode_reg;
    assign O_EFF_ADDR   = init_mode_reg ? `MSR_DEF_ADDR  : cfg_addr_reg;
    assign O_EFF_BAUD   = init_mode_reg ? `MSR_DEF_BAUD  : cfg_baud_reg;
    assign O_EFF_CKSUM  = init_mode_reg ? `MSR_DEF_CKSUM : cfg_cksum_reg;
    assign O_EFF_PROTO  = init_mode_reg ? `MSR_DEF_PROTO : cfg_proto_reg;
    assign O_STORED_CFG = {cfg_baud_reg, cfg_proto_reg, cfg_cksum_reg,
                           cfg_addr_reg};

    // Host watchdog
    logic tenth_tick;
    logic hwdt_restart;
    logic hwdt_fire;
    logic hstat_clr;
    assign hwdt_restart = (cmd_take && hwdt_en_reg) || !hwdt_en_reg ||
                          mod_rst_reg;

    msr_tick #(
        .CYCLES (TENTH_CYCLES)
    ) u_tenth (
        .i_clk   (I_CORE_CLK),
        .i_rst_n (I_RST_N),
        .i_clear (hwdt_restart),
        .o_tick  (tenth_tick)
    );

    // A zero timeout never fires, so it acts as an endless wait
    assign hwdt_fire = hwdt_en_reg && !hwdt_restart && !hwdt_stat_reg &&
                       tenth_tick && (hwdt_tmo_reg != 8'h00) &&
                       ((hwdt_cnt_reg + 8'h01) == hwdt_tmo_reg);
    assign hstat_clr = wr_en && hit_hstat && I_PWDATA[0];

    always_ff @(posedge I_CORE_CLK or negedge I_RST_N)
    begin
        if (!I_RST_N)
        begin
            hwdt_cnt_reg  <= 8'h00;
            hwdt_stat_reg <= 1'b0;
        end
        else
        begin
            if (hwdt_restart || hwdt_fire)
                hwdt_cnt_reg <= 8'h00;
            else if (tenth_tick && !hwdt_stat_reg)
                hwdt_cnt_reg <= hwdt_cnt_reg + 8'h01;
            if (hwdt_fire)
                hwdt_stat_reg <= 1'b1;
            else if (hstat_clr)
                hwdt_stat_reg <= 1'b0;
        end
    end

    assign O_HWDT_TMO = hwdt_stat_reg;

    // Module watchdog
    logic mwdt_fire;
    msr_tick #(
        .CYCLES (MWDT_CYCLES)
    ) u_mwdt (
        .i_clk   (I_CORE_CLK),
        .i_rst_n (I_RST_N),
        .i_clear (I_ALIVE),
        .o_tick  (mwdt_fire)
    );

    logic rflag_clr;
    assign rflag_clr = rsp_end && (kind_reg == CMD_READ_RESET_FLAG);

    always_ff @(posedge I_CORE_CLK or negedge I_RST_N)
    begin
        if (!I_RST_N)
        begin
            mod_rst_reg  <= 1'b0;
            rst_flag_reg <= 1'b1;
        end
        else
        begin
            mod_rst_reg <= mwdt_fire;
            if (mwdt_fire)
                rst_flag_reg <= 1'b1;
            else if (rflag_clr)
                rst_flag_reg <= 1'b0;
        end
    end

    assign O_MOD_RST  = mod_rst_reg;
    assign O_RST_FLAG = rst_flag_reg;

    // Outputs: a tripped host watchdog locks out writes until cleared
    logic [3:0] do_next;
    assign do_next = mod_rst_reg ?
                         (hwdt_stat_reg ? do_safe_reg : do_pwron_reg) :
                     hwdt_fire ? do_safe_reg :
                     (wr_en && hit_do && !hwdt_stat_reg) ? I_PWDATA[3:0] :
                     do_reg;

    always_ff @(posedge I_CORE_CLK or negedge I_RST_N)
    begin
        if (!I_RST_N)
            do_reg <= `MSR_RST_DO_PWRON;
        else
            do_reg <= do_next;
    end

    assign O_DO = do_reg;

    // Interrupts; a read clears only the bits it returned
    logic [`MSR_IRQ_W-1:0] irq_evt;
    logic [`MSR_IRQ_W-1:0] irq_clr;
    assign irq_evt = {cmd_take, mod_rst_reg, hwdt_fire};
    assign irq_clr = (rd_en && hit_istat) ? rdata_reg[`MSR_IRQ_W-1:0] : '0;

    always_ff @(posedge I_CORE_CLK or negedge I_RST_N)
    begin
        if (!I_RST_N)
            irq_stat_reg <= '0;
        else
            irq_stat_reg <= (irq_stat_reg & ~irq_clr) | irq_evt;
    end

    assign O_IRQ = |(irq_stat_reg & irq_mask_reg);
endmodule // msr_top

// ===== verification/msr_top_assertions.sv
`timescale 1ns/1ps
module msr_chk
    import msr_pkg::*;
#(
    parameter int TENTH_CYCLES = 20,
    parameter int MWDT_CYCLES  = 200
) (
    input wire logic              I_CORE_CLK,
    input wire logic              I_RST_N,
    input wire logic              I_ALIVE,
    input wire logic              I_CMD_VALID,
    input wire logic              I_CMD_FOR_ME,
    input wire msr_pkg::msr_cmd_t I_CMD_KIND,
    input wire logic              I_RSP_DONE,
    input wire logic              I_PSEL,
    input wire logic              I_PENABLE,
    input wire logic              I_PWRITE,
    input wire logic [7:0]        I_PADDR,
    input wire logic              O_CMD_ACCEPT,
    input wire logic              O_PWR_LED,
    input wire logic              O_INIT_MODE,
    input wire logic [7:0]        O_EFF_ADDR,
    input wire logic [17:0]       O_EFF_BAUD,
    input wire logic              O_EFF_CKSUM,
    input wire logic              O_EFF_PROTO,
    input wire logic [27:0]       O_STORED_CFG,
    input wire logic              O_RST_FLAG,
    input wire logic              O_HWDT_TMO,
    input wire logic              O_MOD_RST,
    input wire logic [3:0]        O_DO
);
    wire logic cmd_in = I_CMD_VALID && I_CMD_FOR_ME;
    wire logic st_wr = I_PSEL && I_PENABLE && I_PWRITE && I_PADDR == 8'h08;
    default clocking cb @(posedge I_CORE_CLK); endclocking
    default disable iff (!I_RST_N);
    chk_led_off: assert property (
        cmd_in && !O_MOD_RST |=> !O_PWR_LED)
        else $error("indicator lit after command");
    chk_init_dflt: assert property (
        O_INIT_MODE |-> O_EFF_ADDR == 8'h00 && O_EFF_BAUD == 18'h02580
        && !O_EFF_CKSUM && !O_EFF_PROTO)
        else $error("init mode not using defaults");
    // Address bits stay writable outside init, so only baud and flags
    chk_cfg_lock: assert property (
        !O_INIT_MODE |=> $stable(O_STORED_CFG[27:8]))
        else $error("baud or flags changed outside init");
    chk_sel_gate: assert property (
        cmd_in && I_CMD_KIND == CMD_SELECT_PROTOCOL && !O_INIT_MODE
        |-> !O_CMD_ACCEPT)
        else $error("protocol select accepted outside init");
    chk_safe_hold: assert property (
        O_HWDT_TMO && $past(O_HWDT_TMO) && !O_MOD_RST && !$past(O_MOD_RST)
        |-> $stable(O_DO))
        else $error("outputs moved during host timeout");
    chk_htmo_sticky: assert property (
        O_HWDT_TMO && !st_wr |=> O_HWDT_TMO)
        else $error("timeout status dropped without write");
    chk_flag_clear: assert property (
        $fell(O_RST_FLAG) |-> $past(I_RSP_DONE) && !$past(O_PWR_LED))
        else $error("reset flag cleared outside reply");
    chk_flag_mwdt: assert property (
        O_MOD_RST |-> ##[1:2] O_RST_FLAG)
        else $error("reset flag not set by module watchdog");
    chk_mwdt_quiet: assert property (
        I_ALIVE |=> !O_MOD_RST [*8])
        else $error("module watchdog fired despite activity");
    cover property (cmd_in ##1 !O_PWR_LED ##[1:8] O_PWR_LED);
    cover property ($rose(O_HWDT_TMO));
    cover property (O_MOD_RST);
endmodule // msr_chk

bind msr_top msr_chk #(.TENTH_CYCLES(TENTH_CYCLES),
    .MWDT_CYCLES(MWDT_CYCLES)) u_chk (.I_CORE_CLK(I_CORE_CLK),
    .I_RST_N(I_RST_N), .I_ALIVE(I_ALIVE), .I_CMD_VALID(I_CMD_VALID),
    .I_CMD_FOR_ME(I_CMD_FOR_ME), .I_CMD_KIND(I_CMD_KIND),
    .I_RSP_DONE(I_RSP_DONE), .I_PSEL(I_PSEL), .I_PENABLE(I_PENABLE),
    .I_PWRITE(I_PWRITE), .I_PADDR(I_PADDR), .O_CMD_ACCEPT(O_CMD_ACCEPT),
    .O_PWR_LED(O_PWR_LED), .O_INIT_MODE(O_INIT_MODE),
    .O_EFF_ADDR(O_EFF_ADDR), .O_EFF_BAUD(O_EFF_BAUD),
    .O_EFF_CKSUM(O_EFF_CKSUM), .O_EFF_PROTO(O_EFF_PROTO),
    .O_STORED_CFG(O_STORED_CFG), .O_RST_FLAG(O_RST_FLAG),
    .O_HWDT_TMO(O_HWDT_TMO), .O_MOD_RST(O_MOD_RST), .O_DO(O_DO));

// ===== verification/msr_host_model.sv
`timescale 1ns/1ps
module msr_host_model (
    input  wire logic         i_clk,
    input  wire logic         i_accept,
    output logic              o_valid    = 1'b0,
    output logic              o_for_me   = 1'b0,
    output msr_pkg::msr_cmd_t o_kind     = msr_pkg::CMD_OTHER,
    output logic [7:0]        o_addr     = 8'hA5,
    output logic [17:0]       o_baud     = 18'h15A5A,
    output logic              o_cksum    = 1'b1,
    output logic              o_proto    = 1'b1,
    output logic              o_rsp_done = 1'b0
);
    import msr_pkg::*;
    task automatic send(input msr_cmd_t k, input logic me,
                        input logic [7:0] a, input logic [17:0] b,
                        input logic c, input logic p, input int lat,
                        output logic ok);
        @(posedge i_clk);
        o_valid <= 1'b1;
        o_for_me <= me;
        o_kind <= k;
        o_addr <= a;
        o_baud <= b;
        o_cksum <= c;
        o_proto <= p;
        #1;
        ok = i_accept;
        @(posedge i_clk);
        o_valid <= 1'b0;
        // Fields other than kind and proto turn to junk off the strobe so stale copies never pass
        o_for_me <= ~me;
        o_addr <= ~a;
        o_baud <= ~b;
        o_cksum <= ~c;
        repeat (lat) @(posedge i_clk);
        if (me)
        begin
            o_rsp_done <= 1'b1;
            @(posedge i_clk);
            o_rsp_done <= 1'b0;
        end
        #1;
    endtask
endmodule // msr_host_model

// ===== verification/tb.sv
`timescale 1ns/1ps
module tb;
    import msr_pkg::*;
    logic        clk = 1'b0, rst_n = 1'b0, init_n = 1'b1, alive = 1'b0;
    logic        alive_en = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
    logic        err, ok, led, im, mr, ht, rf, ir, cv, cm, cc, cp, rd;
    logic        ec, ep, rdy, ac, se;
    logic [7:0]  paddr = 8'h00, a, ea, ca;
    logic [31:0] pwdata = 32'h0, prd, q, v;
    logic [17:0] eb, cb;
    logic [27:0] sc;
    logic [3:0]  dout, s, p;
    msr_cmd_t    ck;
    int          seed, fail_count = 0, n_checks = 0, i;
    msr_top #(.TENTH_CYCLES(20), .MWDT_CYCLES(200)) uut (
        .I_CORE_CLK(clk), .I_RST_N(rst_n), .I_INIT_N(init_n),
        .I_ALIVE(alive), .I_CMD_VALID(cv), .I_CMD_FOR_ME(cm),
        .I_CMD_KIND(ck), .I_CMD_ADDR(ca), .I_CMD_BAUD(cb),
        .I_CMD_CKSUM(cc), .I_CMD_PROTO(cp), .I_RSP_DONE(rd),
        .I_PSEL(psel), .I_PENABLE(pen), .I_PWRITE(pwr),
        .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prd),
        .O_PREADY(rdy), .O_PSLVERR(err), .O_CMD_ACCEPT(ok),
        .O_PWR_LED(led), .O_INIT_MODE(im), .O_EFF_ADDR(ea),
        .O_EFF_BAUD(eb), .O_EFF_CKSUM(ec), .O_EFF_PROTO(ep),
        .O_STORED_CFG(sc), .O_RST_FLAG(rf), .O_HWDT_TMO(ht),
        .O_MOD_RST(mr), .O_DO(dout), .O_IRQ(ir));
    msr_host_model host (.i_clk(clk), .i_accept(ok), .o_valid(cv),
        .o_for_me(cm), .o_kind(ck), .o_addr(ca), .o_baud(cb),
        .o_cksum(cc), .o_proto(cp), .o_rsp_done(rd));
    always #5 clk = ~clk;
    always @(posedge clk) alive <= alive_en;
    task automatic check(input logic [31:0] seen, exp);
        n_checks++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("mismatch t=%0t seen %h exp %h", $time, seen, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] ad,
                       input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pen <= 1'b0;
        pwr <= w;
        paddr <= ad;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        @(posedge clk);
        while (rdy !== 1'b1)
            @(posedge clk);
        q = prd;
        se = err;
        psel <= 1'b0;
        pen <= 1'b0;
        #1;
    endtask
    // Outside init the stored rate is still the power-up 9600 here
    function automatic logic exp_acc(input msr_cmd_t k, input logic m,
                                     input logic [17:0] b);
        if (k == CMD_SELECT_PROTOCOL)
            return m;
        return m || k != CMD_SET_CONFIG || b == 18'h02580;
    endfunction
    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    initial
    begin
        #100000;
        fail_count++;
        complete_run();
    end
    initial
    begin
        seed = 46;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        #1;
        check(rf, 1'b1);
        check(dout, 4'h0);
        a = $random(seed);
        for (i = 0; i < 5; i++)
        begin
            host.send(msr_cmd_t'(i), 1'b1, a, 18'h02580, 1'b0, 1'b0, i, ac);
            check(ac, exp_acc(msr_cmd_t'(i), 1'b0, 18'h02580));
        end
        check(rf, 1'b0);
        check(ea, a);
        host.send(CMD_SET_CONFIG, 1'b1, ~a, 18'h04B00, 1'b0, 1'b0, 1, ac);
        check(ac, exp_acc(CMD_SET_CONFIG, 1'b0, 18'h04B00));
        fork
            host.send(CMD_READ_CONFIG, 1'b1, a, 18'h02580, 1'b0, 1'b0, 5, ac);
            begin
                repeat (3) @(posedge clk);
                #1;
                check(led, 1'b0);
            end
        join
        check(led, 1'b1);
        check(rf, 1'b0);
        host.send(CMD_READ_RESET_FLAG, 1'b0, a, 18'h0, 1'b0, 1'b0, 1, ac);
        check({ac, led}, 2'b01);
        v = $random(seed);
        apb(1'b1, 8'h0C, v);
        apb(1'b0, 8'h0C, 32'h0);
        check(q, {24'h0, v[7:0]});
        apb(1'b1, 8'h10, v);
        apb(1'b0, 8'h10, 32'h0);
        check(q, 32'h02580);
        apb(1'b0, 8'h3C, 32'h0);
        check(se, 1'b1);
        check(q, 32'h0);
        check(rdy, 1'b1);
        s = $random(seed);
        p = ~s;
        apb(1'b1, 8'h14, {28'h0, s});
        apb(1'b1, 8'h18, {28'h0, p});
        apb(1'b1, 8'h1C, 32'h5);
        check(dout, 4'h5);
        apb(1'b1, 8'h28, 32'h3);
        apb(1'b1, 8'h04, 32'h2);
        apb(1'b1, 8'h00, 32'h1);
        for (i = 0; i < 10; i++)
            host.send(CMD_OTHER, 1'b1, a, 18'h0, 1'b0, 1'b0, 1, ac);
        check(ht, 1'b0);
        repeat (30) @(posedge clk);
        #1;
        check(ht, 1'b0);
        repeat (15) @(posedge clk);
        #1;
        check({ht, ir, dout}, {2'b11, s});
        apb(1'b1, 8'h1C, 32'hA);
        check(dout, s);
        apb(1'b0, 8'h24, 32'h0);
        check(q[0], 1'b1);
        apb(1'b0, 8'h24, 32'h0);
        check({q[0], ir}, 2'b00);
        apb(1'b1, 8'h00, 32'h0);
        apb(1'b1, 8'h08, 32'h0);
        check(ht, 1'b1);
        apb(1'b1, 8'h08, 32'h1);
        check(ht, 1'b0);
        apb(1'b1, 8'h1C, {28'h0, s});
        alive_en <= 1'b0;
        for (i = 0; i < 400 && mr !== 1'b1; i++)
            @(posedge clk);
        alive_en <= 1'b1;
        repeat (3) @(posedge clk);
        #1;
        check({rf, dout}, {1'b1, p});
        apb(1'b0, 8'h24, 32'h0);
        check(q[1], 1'b1);
        @(posedge clk);
        init_n <= 1'b0;
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        repeat (6) @(posedge clk);
        init_n <= 1'b1;
        #1;
        check({im, dout}, 5'h10);
        check({ea, eb, ec, ep}, {8'h00, 18'h02580, 2'b00});
        a = $random(seed);
        host.send(CMD_SET_CONFIG, 1'b1, a, 18'h04B00, 1'b1, 1'b0, 2, ac);
        check(ac, exp_acc(CMD_SET_CONFIG, 1'b1, 18'h04B00));
        host.send(CMD_SELECT_PROTOCOL, 1'b1, a, 18'h04B00, 1'b1, 1'b1, 2, ac);
        check(ac, exp_acc(CMD_SELECT_PROTOCOL, 1'b1, 18'h0));
        check(sc, {18'h04B00, 2'b11, a});
        check({ea, eb, ec, ep}, {8'h00, 18'h02580, 2'b00});
        check(im, 1'b1);
        complete_run();
    end
endmodule // tb
